// [rtl/flash_prot_consts.svh]
`ifndef FLASH_PROT_CONSTS_SVH
`define FLASH_PROT_CONSTS_SVH

// register byte offsets
`define OFS_FAULT_STATUS 8'h00
`define OFS_PROT 8'h04
`define OFS_CONFIG 8'h08
`define OFS_CMD_STATUS 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14

// fault status fields
`define FS_SINGLE_BIT 0
`define FS_DOUBLE_BIT 1
`define FS_MASK 8'h03

// config fields
`define CFG_IGNORE_SF_BIT 0
`define CFG_MASK 8'h01

// command status fields
`define CS_PROT_VIOL_BIT 4

// interrupt status fields
`define IRQ_SINGLE_BIT 0
`define IRQ_DOUBLE_BIT 1
`define IRQ_COLLIDE_BIT 2
`define IRQ_VIOL_BIT 3
`define IRQ_MASK_BITS 8'h0F

// protection register fields
`define PR_POL_BIT 7
`define PR_RNV_BIT 6
`define PR_HDIS_BIT 5
`define PR_HS_HI 4
`define PR_HS_LO 3
`define PR_LDIS_BIT 2
`define PR_LS_HI 1
`define PR_LS_LO 0
`define PR_FULL_PROT 8'h7F
`define PR_RESET 8'h7F

// nonvolatile protection byte and ranges (global addresses)
`define NV_PROT_ADDR 18'h3FF0C
`define HI_RANGE_END 18'h3FFFF
`define LO_RANGE_BASE 18'h38000
`define HI_BASE_0 18'h3F800
`define HI_BASE_1 18'h3F000
`define HI_BASE_2 18'h3E000
`define HI_BASE_3 18'h3C000
`define LO_END_0 18'h383FF
`define LO_END_1 18'h387FF
`define LO_END_2 18'h38FFF
`define LO_END_3 18'h39FFF

// allowed scenario transitions, one mask of targets per source
`define SCEN_ALLOW_0 8'h0F
`define SCEN_ALLOW_1 8'h0A
`define SCEN_ALLOW_2 8'h0C
`define SCEN_ALLOW_3 8'h08
`define SCEN_ALLOW_4 8'h18
`define SCEN_ALLOW_5 8'h3C
`define SCEN_ALLOW_6 8'h5A
`define SCEN_ALLOW_7 8'hFF

`endif

// [rtl/flash_prot_pkg.sv]
package flash_prot_pkg;

    // outcome of one flash array read
    typedef struct packed {
        logic valid;
        logic singleFault;
        logic doubleFault;
        logic collision;
    } flash_read_t;

    // program or erase request from the command sequencer
    typedef struct packed {
        logic valid;
        logic blockErase;
        logic [17:0] addr;
    } flash_cmd_t;

    // nonvolatile protection byte delivered during reset
    typedef struct packed {
        logic valid;
        logic doubleFault;
        logic [7:0] data;
    } nv_load_t;

    typedef enum logic [1:0] {
        LOAD_WAIT,
        LOAD_DONE
    } load_state_t;

endpackage

// [rtl/flash_fault_status_and_protection.sv]
`timescale 1ns/100ps
`include "flash_prot_consts.svh"
// Behaviour
// - double fault on array read sets bit1
// - writing one clears double fault flag
// - corrected single fault sets bit0 unless ignored
// - writing one clears single fault flag
// - genuine fault sets single or double, never both
// - read during busy block sets both flags
// - protection writes only enlarge protected region
// - reset loads protection from nonvolatile byte
// - reset double fault forces full protection
// - program/erase into protected area refused, flagged
// - block erase refused if any sector protected
// - polarity bit7 selects protected or unprotected ranges
// - bit5 disables high range ending 0x3FFFF
// - high size writable only while high disabled
// - bit2 disables low range starting 0x38000
// - low size writable only while low disabled
// - disallowed scenario writes ignored, register shows active
module flash_fault_status_and_protection #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // flash array side
    input wire flash_prot_pkg::flash_read_t arrayRead,
    input wire flash_prot_pkg::flash_cmd_t cmdReq,
    output logic cmdGranted,
    output logic cmdRefused,
    // reset load of the protection byte
    input wire flash_prot_pkg::nv_load_t nvLoad,
    output logic nvLoadReq,
    output logic [17:0] nvLoadAddr,
    output logic [7:0] protOut,
    // interrupt
    output logic irq
);
    import flash_prot_pkg::*;

    logic [7:0] faultStatus_reg;
    logic [7:0] prot_reg;
    logic [7:0] prot_next;
    logic [7:0] config_reg;
    logic [7:0] cmdStatus_reg;
    logic [7:0] irqStatus_reg;
    logic [7:0] irqMask_reg;
    logic [7:0] rdSnap_reg;
    load_state_t loadState_reg;
    logic setupPhase;
    logic accessDone;
    logic wrDone;
    logic rdDone;
    logic mapped;
    logic [7:0] addr8;
    logic [7:0] rdMux;
    logic setSingle;
    logic setDouble;
    logic setViol;
    logic inHigh;
    logic inLow;
    logic addrProtected;
    logic anyProtected;
    logic [17:0] hiBase;
    logic [17:0] loEnd;
    logic [2:0] scenCur;
    logic [2:0] scenNew;
    logic [7:0] allowMask;
    logic [7:0] wByte;

    // ---------------- apb slave ----------------
    // no wait state: pready rises in the first access cycle
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign wrDone = accessDone && pwrite;
    assign rdDone = accessDone && !pwrite;
    assign addr8 = 8'(paddr);
    assign wByte = pwdata[7:0];

    always_comb begin
        mapped = 1'b1;
        case (addr8)
            `OFS_FAULT_STATUS: rdMux = faultStatus_reg & `FS_MASK;
            `OFS_PROT: rdMux = prot_reg;
            `OFS_CONFIG: rdMux = config_reg;
            `OFS_CMD_STATUS: rdMux = cmdStatus_reg;
            `OFS_IRQ_STATUS: rdMux = irqStatus_reg;
            `OFS_IRQ_MASK: rdMux = irqMask_reg;
            default: begin
                rdMux = 8'h00;
                mapped = 1'b0;
            end
        endcase
        if (paddr[ADDR_W-1:0] != ADDR_W'(addr8)) begin
            rdMux = 8'h00;
            mapped = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            rdSnap_reg <= 8'h00;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase && !mapped;
            if (setupPhase) begin
                prdata <= {24'h000000, rdMux};
                rdSnap_reg <= rdMux;
            end
        end
    end

    // ---------------- fault status ----------------
    // a collision reports both flags; a genuine fault only one of them
    assign setDouble = arrayRead.valid &&
        (arrayRead.collision || arrayRead.doubleFault);
    assign setSingle = arrayRead.valid && (arrayRead.collision ||
        (arrayRead.singleFault && !arrayRead.doubleFault &&
         !config_reg[`CFG_IGNORE_SF_BIT]));

    // set wins over a same-cycle write-one clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            faultStatus_reg <= 8'h00;
        end else begin
            if (setDouble) begin
                faultStatus_reg[`FS_DOUBLE_BIT] <= 1'b1;
            end else if (wrDone && addr8 == `OFS_FAULT_STATUS &&
                         wByte[`FS_DOUBLE_BIT]) begin
                faultStatus_reg[`FS_DOUBLE_BIT] <= 1'b0;
            end
            if (setSingle) begin
                faultStatus_reg[`FS_SINGLE_BIT] <= 1'b1;
            end else if (wrDone && addr8 == `OFS_FAULT_STATUS &&
                         wByte[`FS_SINGLE_BIT]) begin
                faultStatus_reg[`FS_SINGLE_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            config_reg <= 8'h00;
        end else if (wrDone && addr8 == `OFS_CONFIG) begin
            config_reg <= wByte & `CFG_MASK;
        end
    end

    // ---------------- protection decode ----------------
    always_comb begin
        case (prot_reg[`PR_HS_HI:`PR_HS_LO])
            2'b00: hiBase = `HI_BASE_0;
            2'b01: hiBase = `HI_BASE_1;
            2'b10: hiBase = `HI_BASE_2;
            default: hiBase = `HI_BASE_3;
        endcase
        case (prot_reg[`PR_LS_HI:`PR_LS_LO])
            2'b00: loEnd = `LO_END_0;
            2'b01: loEnd = `LO_END_1;
            2'b10: loEnd = `LO_END_2;
            default: loEnd = `LO_END_3;
        endcase
    end

    assign inHigh = !prot_reg[`PR_HDIS_BIT] && cmdReq.addr >= hiBase &&
        cmdReq.addr <= `HI_RANGE_END;
    assign inLow = !prot_reg[`PR_LDIS_BIT] &&
        cmdReq.addr >= `LO_RANGE_BASE && cmdReq.addr <= loEnd;
    // polarity set: ranges are protected; clear: ranges are the holes
    assign addrProtected = prot_reg[`PR_POL_BIT] ? (inHigh || inLow) :
        !(inHigh || inLow);
    // the open ranges never cover a whole block, so clear polarity
    // always leaves some sector of the block protected
    assign anyProtected = prot_reg[`PR_POL_BIT] ?
        !(prot_reg[`PR_HDIS_BIT] && prot_reg[`PR_LDIS_BIT]) : 1'b1;
    assign setViol = cmdReq.valid && (cmdReq.blockErase ? anyProtected :
        addrProtected);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdGranted <= 1'b0;
            cmdRefused <= 1'b0;
        end else begin
            cmdGranted <= cmdReq.valid && !setViol;
            cmdRefused <= setViol;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmdStatus_reg <= 8'h00;
        end else if (setViol) begin
            cmdStatus_reg[`CS_PROT_VIOL_BIT] <= 1'b1;
        end else if (wrDone && addr8 == `OFS_CMD_STATUS &&
                     wByte[`CS_PROT_VIOL_BIT]) begin
            cmdStatus_reg[`CS_PROT_VIOL_BIT] <= 1'b0;
        end
    end

    // ---------------- protection register writes ----------------
    // scenario index {polarity, high disable, low disable}: 7 is open and
    // 3 is full protection, so every allowed move only adds protection
    assign scenCur = {prot_reg[`PR_POL_BIT], prot_reg[`PR_HDIS_BIT],
        prot_reg[`PR_LDIS_BIT]};
    assign scenNew = {wByte[`PR_POL_BIT], wByte[`PR_HDIS_BIT],
        wByte[`PR_LDIS_BIT]};

    always_comb begin
        case (scenCur)
            3'd0: allowMask = `SCEN_ALLOW_0;
            3'd1: allowMask = `SCEN_ALLOW_1;
            3'd2: allowMask = `SCEN_ALLOW_2;
            3'd3: allowMask = `SCEN_ALLOW_3;
            3'd4: allowMask = `SCEN_ALLOW_4;
            3'd5: allowMask = `SCEN_ALLOW_5;
            3'd6: allowMask = `SCEN_ALLOW_6;
            default: allowMask = `SCEN_ALLOW_7;
        endcase
        prot_next = prot_reg;
        if (allowMask[scenNew]) begin
            prot_next[`PR_POL_BIT] = wByte[`PR_POL_BIT];
            prot_next[`PR_HDIS_BIT] = wByte[`PR_HDIS_BIT];
            prot_next[`PR_LDIS_BIT] = wByte[`PR_LDIS_BIT];
            if (prot_reg[`PR_HDIS_BIT]) begin
                prot_next[`PR_HS_HI:`PR_HS_LO] =
                    wByte[`PR_HS_HI:`PR_HS_LO];
            end
            if (prot_reg[`PR_LDIS_BIT]) begin
                prot_next[`PR_LS_HI:`PR_LS_LO] =
                    wByte[`PR_LS_HI:`PR_LS_LO];
            end
        end
    end

    // until the byte arrives the register sits at full protection,
    // so an early command can never slip through
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prot_reg <= `PR_RESET;
            loadState_reg <= LOAD_WAIT;
        end else begin
            case (loadState_reg)
                LOAD_WAIT: begin
                    if (nvLoad.valid) begin
                        loadState_reg <= LOAD_DONE;
                        if (nvLoad.doubleFault) begin
                            prot_reg <= `PR_FULL_PROT;
                        end else begin
                            prot_reg <= nvLoad.data;
                        end
                    end
                end
                LOAD_DONE: begin
                    if (wrDone && addr8 == `OFS_PROT) begin
                        prot_reg <= prot_next;
                    end
                end
                default: loadState_reg <= LOAD_WAIT;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nvLoadReq <= 1'b1;
            nvLoadAddr <= `NV_PROT_ADDR;
            protOut <= `PR_RESET;
        end else begin
            nvLoadReq <= loadState_reg == LOAD_WAIT && !nvLoad.valid;
            nvLoadAddr <= `NV_PROT_ADDR;
            protOut <= prot_reg;
        end
    end

    // ---------------- interrupts ----------------
    // read clears only what the read returned, so a later event survives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqStatus_reg <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (rdDone && addr8 == `OFS_IRQ_STATUS && rdSnap_reg[i]) begin
                    irqStatus_reg[i] <= 1'b0;
                end
            end
            if (setSingle && !arrayRead.collision) begin
                irqStatus_reg[`IRQ_SINGLE_BIT] <= 1'b1;
            end
            if (setDouble && !arrayRead.collision) begin
                irqStatus_reg[`IRQ_DOUBLE_BIT] <= 1'b1;
            end
            if (arrayRead.valid && arrayRead.collision) begin
                irqStatus_reg[`IRQ_COLLIDE_BIT] <= 1'b1;
            end
            if (setViol) begin
                irqStatus_reg[`IRQ_VIOL_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irqMask_reg <= 8'h00;
            irq <= 1'b0;
        end else begin
            if (wrDone && addr8 == `OFS_IRQ_MASK) begin
                irqMask_reg <= wByte & `IRQ_MASK_BITS;
            end
            irq <= |(irqStatus_reg & irqMask_reg);
        end
    end

    // ---------------- assertions ----------------
    sequence s_protWrite;
        wrDone && addr8 == `OFS_PROT && loadState_reg == LOAD_DONE;
    endsequence

    property p_doubleSet;
        @(posedge clk) disable iff (rst)
        setDouble |=> faultStatus_reg[`FS_DOUBLE_BIT];
    endproperty
    a_doubleSet: assert property (p_doubleSet)
        else $error("double fault flag not set");

    property p_doubleClear;
        @(posedge clk) disable iff (rst)
        wrDone && addr8 == `OFS_FAULT_STATUS && wByte[`FS_DOUBLE_BIT] &&
        !setDouble |=> !faultStatus_reg[`FS_DOUBLE_BIT];
    endproperty
    a_doubleClear: assert property (p_doubleClear)
        else $error("double fault flag not cleared");

    property p_singleHold;
        @(posedge clk) disable iff (rst)
        !setSingle && !(wrDone && addr8 == `OFS_FAULT_STATUS &&
        wByte[`FS_SINGLE_BIT]) |=> $stable(faultStatus_reg[`FS_SINGLE_BIT]);
    endproperty
    a_singleHold: assert property (p_singleHold)
        else $error("single fault flag changed without cause");

    property p_ignoreSingle;
        @(posedge clk) disable iff (rst)
        arrayRead.valid && !arrayRead.collision &&
        config_reg[`CFG_IGNORE_SF_BIT] && !faultStatus_reg[`FS_SINGLE_BIT]
        |=> !faultStatus_reg[`FS_SINGLE_BIT];
    endproperty
    a_ignoreSingle: assert property (p_ignoreSingle)
        else $error("ignored single fault was recorded");

    property p_exclusive;
        @(posedge clk) disable iff (rst)
        arrayRead.valid && !arrayRead.collision |-> !(setSingle && setDouble);
    endproperty
    a_exclusive: assert property (p_exclusive)
        else $error("genuine fault set both flags");

    property p_collision;
        @(posedge clk) disable iff (rst)
        arrayRead.valid && arrayRead.collision |=>
        faultStatus_reg[`FS_SINGLE_BIT] && faultStatus_reg[`FS_DOUBLE_BIT];
    endproperty
    a_collision: assert property (p_collision)
        else $error("collision did not set both flags");

    property p_noShrink;
        @(posedge clk) disable iff (rst)
        (s_protWrite and !allowMask[scenNew]) |=> $stable(prot_reg);
    endproperty
    a_noShrink: assert property (p_noShrink)
        else $error("disallowed protection write took effect");

    property p_fullOnFault;
        @(posedge clk) disable iff (rst)
        loadState_reg == LOAD_WAIT && nvLoad.valid && nvLoad.doubleFault
        |=> prot_reg == `PR_FULL_PROT ##1 protOut == `PR_FULL_PROT;
    endproperty
    a_fullOnFault: assert property (p_fullOnFault)
        else $error("reset fault did not force full protection");

    property p_refuse;
        @(posedge clk) disable iff (rst)
        cmdReq.valid && addrProtected && !cmdReq.blockErase
        |=> cmdRefused && !cmdGranted && cmdStatus_reg[`CS_PROT_VIOL_BIT];
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("protected program not refused");

    property p_hiSizeLocked;
        @(posedge clk) disable iff (rst)
        (s_protWrite and !prot_reg[`PR_HDIS_BIT]) |=>
        $stable(prot_reg[`PR_HS_HI:`PR_HS_LO]);
    endproperty
    a_hiSizeLocked: assert property (p_hiSizeLocked)
        else $error("high size changed while range active");

    property p_loSizeLocked;
        @(posedge clk) disable iff (rst)
        (s_protWrite and !prot_reg[`PR_LDIS_BIT]) |=>
        $stable(prot_reg[`PR_LS_HI:`PR_LS_LO]);
    endproperty
    a_loSizeLocked: assert property (p_loSizeLocked)
        else $error("low size changed while range active");

    property p_reservedZero;
        @(posedge clk) disable iff (rst)
        setupPhase && addr8 == `OFS_FAULT_STATUS |=> prdata[7:2] == 6'h00;
    endproperty
    a_reservedZero: assert property (p_reservedZero)
        else $error("fault status reserved bits not zero");

endmodule // flash_fault_status_and_protection

// [sim/test_flash_fault_status_and_protection.sv]
`timescale 1ns/100ps
`include "flash_prot_consts.svh"
module test_flash_fault_status_and_protection;
    import flash_prot_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    flash_read_t arrayRead = '0;
    flash_cmd_t cmdReq = '0;
    logic cmdGranted;
    logic cmdRefused;
    nv_load_t nvLoad = '0;
    logic nvLoadReq;
    logic [17:0] nvLoadAddr;
    logic [7:0] protOut;
    logic irq;
    int n_fail = 0;
    int n_tests = 0;

    flash_fault_status_and_protection #(.ADDR_W(8)) i_dut (
        .clk(clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr),
        .arrayRead(arrayRead), .cmdReq(cmdReq),
        .cmdGranted(cmdGranted), .cmdRefused(cmdRefused),
        .nvLoad(nvLoad), .nvLoadReq(nvLoadReq), .nvLoadAddr(nvLoadAddr),
        .protOut(protOut), .irq(irq)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s saw %h want %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("tests %0d, failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // entered right after a rising edge; leaves one idle cycle behind
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        check(32'(n), 32'h1, "apb wait states");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, {24'h0, d}, rd, err);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        check(rd, {24'h0, exp}, "register read");
        check({31'h0, err}, 32'h0, "slave error");
    endtask

    task automatic fault_ev(input logic s, input logic d, input logic c);
        arrayRead <= {1'b1, s, d, c};
        @(posedge clk);
        arrayRead <= '0;
        @(posedge clk);
    endtask

    task automatic cmd(input logic be, input logic [17:0] a,
                       input logic grant);
        cmdReq <= {1'b1, be, a};
        @(posedge clk);
        cmdReq <= '0;
        @(posedge clk);
        check({30'h0, cmdGranted, cmdRefused}, grant ? 32'h2 : 32'h1,
              "command answer");
    endtask

    task automatic do_reset_load(input logic df, input logic [7:0] d);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        check({5'h0, nvLoadReq, protOut, nvLoadAddr},
              {5'h0, 1'b1, `PR_RESET, `NV_PROT_ADDR}, "reset");
        rst <= 1'b0;
        @(posedge clk);
        nvLoad <= {1'b1, df, d};
        @(posedge clk);
        nvLoad <= '0;
        repeat (2) @(posedge clk);
        check({31'h0, nvLoadReq}, 32'h0, "load request dropped");
    endtask

    task automatic t_faults;
        wr_reg(`OFS_CONFIG, 8'h00);
        fault_ev(1'b0, 1'b1, 1'b0);
        rd_reg(`OFS_FAULT_STATUS, 8'h02);
        wr_reg(`OFS_FAULT_STATUS, 8'h01);
        rd_reg(`OFS_FAULT_STATUS, 8'h02);
        wr_reg(`OFS_FAULT_STATUS, 8'hFE);
        rd_reg(`OFS_FAULT_STATUS, 8'h00);
        fault_ev(1'b1, 1'b0, 1'b0);
        rd_reg(`OFS_FAULT_STATUS, 8'h01);
        wr_reg(`OFS_FAULT_STATUS, 8'h02);
        rd_reg(`OFS_FAULT_STATUS, 8'h01);
        wr_reg(`OFS_FAULT_STATUS, 8'h01);
        rd_reg(`OFS_FAULT_STATUS, 8'h00);
        fault_ev(1'b0, 1'b0, 1'b1);
        rd_reg(`OFS_FAULT_STATUS, 8'h03);
        wr_reg(`OFS_FAULT_STATUS, 8'h03);
        wr_reg(`OFS_CONFIG, 8'h01);
        fault_ev(1'b1, 1'b0, 1'b0);
        rd_reg(`OFS_FAULT_STATUS, 8'h00);
        wr_reg(`OFS_CONFIG, 8'h00);
    endtask

    task automatic t_irq;
        logic [31:0] rd;
        logic err;
        // drain whatever earlier events left pending
        apb(1'b0, `OFS_IRQ_STATUS, 32'h0, rd, err);
        wr_reg(`OFS_IRQ_MASK, 8'h00);
        fault_ev(1'b1, 1'b0, 1'b0);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0, "masked interrupt");
        wr_reg(`OFS_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1, "unmasked interrupt");
        rd_reg(`OFS_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0, "interrupt cleared");
        wr_reg(`OFS_FAULT_STATUS, 8'h01);
        apb(1'b0, 8'h18, 32'h0, rd, err);
        check({rd[30:0], err}, 32'h1, "unmapped read");
    endtask

    task automatic t_prot_grow;
        rd_reg(`OFS_PROT, 8'hE4);
        check({24'h0, protOut}, 32'hE4, "protection out");
        cmd(1'b0, 18'h38000, 1'b1);
        cmd(1'b1, 18'h00000, 1'b1);
        wr_reg(`OFS_PROT, 8'hFD);
        rd_reg(`OFS_PROT, 8'hFD);
        wr_reg(`OFS_PROT, 8'hF9);
        rd_reg(`OFS_PROT, 8'hF9);
        cmd(1'b0, 18'h38400, 1'b0);
        rd_reg(`OFS_CMD_STATUS, 8'h10);
        wr_reg(`OFS_CMD_STATUS, 8'h10);
        cmd(1'b0, 18'h38800, 1'b1);
        cmd(1'b1, 18'h00000, 1'b0);
        wr_reg(`OFS_PROT, 8'hF8);
        rd_reg(`OFS_PROT, 8'hF9);
        wr_reg(`OFS_PROT, 8'hFD);
        rd_reg(`OFS_PROT, 8'hF9);
        wr_reg(`OFS_PROT, 8'hD9);
        rd_reg(`OFS_PROT, 8'hD9);
        cmd(1'b0, 18'h3C000, 1'b0);
        cmd(1'b0, 18'h3BFFF, 1'b1);
        wr_reg(`OFS_PROT, 8'hC1);
        rd_reg(`OFS_PROT, 8'hD9);
        wr_reg(`OFS_PROT, 8'h59);
        rd_reg(`OFS_PROT, 8'hD9);
    endtask

    task automatic t_bad_load;
        // double fault reported while loading the stored byte
        do_reset_load(1'b1, 8'hE4);
        rd_reg(`OFS_PROT, `PR_FULL_PROT);
        cmd(1'b0, 18'h38000, 1'b0);
        // full protection may not open a low hole
        wr_reg(`OFS_PROT, 8'h7B);
        rd_reg(`OFS_PROT, `PR_FULL_PROT);
        do_reset_load(1'b0, 8'h7B);
        cmd(1'b0, 18'h38000, 1'b1);
        cmd(1'b0, 18'h3A000, 1'b0);
        cmd(1'b1, 18'h00000, 1'b0);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_sim;
    end

    initial begin
        @(posedge clk);
        do_reset_load(1'b0, 8'hE4);
        t_faults;
        t_irq;
        t_prot_grow;
        t_bad_load;
        end_sim;
    end
endmodule // test_flash_fault_status_and_protection
